// ===== core/shift_unit_cfg.svh
`ifndef SHIFT_UNIT_CFG_SVH
`define SHIFT_UNIT_CFG_SVH

`define ADDR_OPCODE 12'h000
`define ADDR_ACC 12'h004
`define ADDR_BUF 12'h008
`define ADDR_STATUS1 12'h00C
`define ADDR_PC 12'h010
`define ADDR_STATE 12'h014
`define ACC_RESET 32'h00000000
`define BUF_RESET 32'h00000000
`define STATUS1_RESET 16'h0000
`define PC_RESET 16'h0000
`define TEST_FLAG_BIT 11
`define SXM_BIT 10
`define CARRY_BIT 9
`define PC_STEP 16'h0001
`define OPC_SFL 16'hBE16
`define OPC_SFR 16'hBE17
`define OPC_SUBB 16'hBE19
`define OPC_SET_TEST 16'hBC4B

`endif

// ===== core/shift_unit_pkg.sv
package shift_unit_pkg;
    typedef enum logic [4:0] {
        OP_NONE = 5'b00001,
        OP_SHL = 5'b00010,
        OP_SHR = 5'b00100,
        OP_SUB = 5'b01000,
        OP_SET = 5'b10000
    } op_kind_t;
endpackage

// ===== core/op_if.sv
`timescale 1ns/100ps
`default_nettype none
interface op_if;
    import shift_unit_pkg::*;
    op_kind_t kind;
    logic [31:0] acc;
    logic [31:0] buffer;
    logic sign_extend_mode_flag;
    logic carry;
    logic [31:0] next_acc;
    logic [31:0] next_buffer;
    logic next_carry;
    modport top (output kind, acc, buffer, sign_extend_mode_flag, carry,
        input next_acc, next_buffer, next_carry);
    modport exec (input kind, acc, buffer, sign_extend_mode_flag, carry,
        output next_acc, next_buffer, next_carry);
endinterface
`default_nettype wire

// ===== core/op_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "shift_unit_cfg.svh"
module op_decode
    import shift_unit_pkg::*;
(
    input wire logic [15:0] word,
    output op_kind_t kind
);
    always_comb begin
        unique case (word)
            `OPC_SFL: kind = OP_SHL;
            `OPC_SFR: kind = OP_SHR;
            `OPC_SUBB: kind = OP_SUB;
            `OPC_SET_TEST: kind = OP_SET;
            default: kind = OP_NONE;
        endcase
    end
endmodule
`default_nettype wire

// ===== core/shift_exec.sv
`timescale 1ns/100ps
`default_nettype none
module shift_exec
    import shift_unit_pkg::*;
(
    op_if.exec dp
);
    logic [32:0] diff;
    assign diff = {1'b0, dp.acc} - {1'b0, dp.buffer};
    always_comb begin
        dp.next_acc = dp.acc;
        dp.next_buffer = dp.buffer;
        dp.next_carry = dp.carry;
        unique case (dp.kind)
            OP_SHL: begin
                dp.next_acc = {dp.acc[30:0], dp.buffer[31]};
                dp.next_buffer = {dp.buffer[30:0], 1'b0};
                dp.next_carry = dp.acc[31];
            end
            OP_SHR: begin
                // Fill is the sign bit gated by the mode bit as held now
                dp.next_acc = {dp.sign_extend_mode_flag & dp.acc[31], dp.acc[31:1]};
                dp.next_buffer = {dp.acc[0], dp.buffer[31:1]};
                dp.next_carry = dp.buffer[0];
            end
            OP_SUB: begin
                dp.next_acc = diff[31:0];
                dp.next_carry = ~diff[32];
            end
            OP_SET, OP_NONE: begin
            end
        endcase
    end
endmodule
`default_nettype wire

// ===== core/accumulator_pair_shift_unit.sv
// How it works
// - Left double shift moves result:buffer left, zero into buffer bit 0.
// - Left double shift carries buffer MSB into result LSB.
// - Left double shift moves result bit 31 into the carry flag.
// - Left double shift touches only carry and ignores sign mode.
// - Right double shift moves pair right; result LSB enters buffer MSB.
// - Sign mode one: result sign bit kept and copied to bit 30.
// - Sign mode zero: result MSB filled with zero.
// - Right double shift moves buffer bit 0 into carry.
// - Shift kind follows the sign mode held when it executes.
// - Test flag set writes status word one bit 11, others kept.
`timescale 1ns/100ps
`default_nettype none
`include "shift_unit_cfg.svh"
module accumulator_pair_shift_unit
    import shift_unit_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic [31:0] acc;
    logic [31:0] result_shadow_buffer;
    logic [15:0] status_word_one;
    logic [15:0] pc;
    logic exec_go;
    logic [15:0] opword;
    logic wr;
    logic rd;
    logic mapped;
    logic [31:0] next_prdata;
    op_kind_t kind;

    op_if dp();

    assign wr = psel & penable & pwrite & ~pready;
    assign rd = psel & penable & ~pwrite & ~pready;
    assign exec_go = wr & (paddr == `ADDR_OPCODE);
    assign opword = pwdata[15:0];

    op_decode u_dec (
        .word(opword),
        .kind(kind)
    );

    assign dp.kind = exec_go ? kind : OP_NONE;
    assign dp.acc = acc;
    assign dp.buffer = result_shadow_buffer;
    assign dp.sign_extend_mode_flag = status_word_one[`SXM_BIT];
    assign dp.carry = status_word_one[`CARRY_BIT];

    shift_exec u_exec (
        .dp(dp)
    );

    always_comb begin
        mapped = 1'b1;
        next_prdata = 32'h00000000;
        unique case (paddr)
            `ADDR_OPCODE: next_prdata = 32'h00000000;
            `ADDR_ACC: next_prdata = acc;
            `ADDR_BUF: next_prdata = result_shadow_buffer;
            `ADDR_STATUS1: next_prdata = {16'h0000, status_word_one};
            `ADDR_PC: next_prdata = {16'h0000, pc};
            `ADDR_STATE: next_prdata = {31'h00000000, dp.next_carry};
            default: mapped = 1'b0;
        endcase
    end

    // One-cycle wait state keeps pready registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (clk_en) begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (rd) begin
                prdata <= next_prdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= `ACC_RESET;
            result_shadow_buffer <= `BUF_RESET;
        end else if (clk_en) begin
            if (exec_go) begin
                acc <= dp.next_acc;
                result_shadow_buffer <= dp.next_buffer;
            end else if (wr && paddr == `ADDR_ACC) begin
                acc <= pwdata;
            end else if (wr && paddr == `ADDR_BUF) begin
                result_shadow_buffer <= pwdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_word_one <= `STATUS1_RESET;
        end else if (clk_en) begin
            if (exec_go) begin
                status_word_one[`CARRY_BIT] <= dp.next_carry;
                if (kind == OP_SET) begin
                    status_word_one[`TEST_FLAG_BIT] <= 1'b1;
                end
            end else if (wr && paddr == `ADDR_STATUS1) begin
                status_word_one <= pwdata[15:0];
            end
        end
    end

    // Unknown opcodes still step the counter, as a no-op would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= `PC_RESET;
        end else if (clk_en) begin
            if (exec_go) begin
                pc <= pc + `PC_STEP;
            end else if (wr && paddr == `ADDR_PC) begin
                pc <= pwdata[15:0];
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/shift_unit_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "shift_unit_cfg.svh"
module shift_unit_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic start;
    assign start = psel && penable && !pready && clk_en;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_one_wait: assert property (
        start |=> pready) else $error("late answer");
    a_ready_pulse: assert property (
        pready && clk_en |=> !pready) else $error("answer too long");
    a_err_ready: assert property (
        pslverr |-> pready) else $error("error without answer");
    a_unmapped_err: assert property (
        start && paddr > 12'h014 |=> pslverr) else $error("no error");
    a_read_hold: assert property (
        $changed(prdata) |-> pready && !pwrite) else $error("data moved");
    a_ready_req: assert property (
        pready |-> psel && penable) else $error("unasked answer");
    a_status_hi: assert property (
        pready && !pwrite && paddr == `ADDR_STATUS1 |-> prdata[31:16] == 16'h0)
        else $error("status upper bits set");
    a_pc_hi: assert property (
        pready && !pwrite && paddr == `ADDR_PC |-> prdata[31:16] == 16'h0)
        else $error("counter upper bits set");
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "shift_unit_cfg.svh"
module tb_top;
    typedef struct {logic [15:0] st, op; logic [31:0] a, b, ea, eb;
        logic [15:0] es;} row_t;
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic pready, pslverr, e;
    int fails = 0, tests_run = 0;
    logic [11:0] regs[4] = '{`ADDR_ACC, `ADDR_BUF, `ADDR_STATUS1, `ADDR_PC};
    row_t rows[8] = '{
        '{16'h0000, `OPC_SFL, 32'hB0001234, 32'hB0001234,
            32'h60002469, 32'h60002468, 16'h0200},
        '{16'h0400, `OPC_SFL, 32'hB0001234, 32'hB0001234,
            32'h60002469, 32'h60002468, 16'h0600},
        '{16'h0200, `OPC_SFR, 32'hB0001235, 32'hB0001234,
            32'h5800091A, 32'hD800091A, 16'h0000},
        '{16'h0400, `OPC_SFR, 32'hB0001234, 32'hB0001234,
            32'hD800091A, 32'h5800091A, 16'h0400},
        '{16'h0400, `OPC_SFR, 32'h40000001, 32'h00000003,
            32'h20000000, 32'h80000001, 16'h0600},
        '{16'h0000, `OPC_SUBB, 32'h20000000, 32'h10000000,
            32'h10000000, 32'h10000000, 16'h0200},
        '{16'h0200, `OPC_SUBB, 32'h10000000, 32'h20000000,
            32'hF0000000, 32'h20000000, 16'h0000},
        '{16'h0600, `OPC_SET_TEST, 32'h12345678, 32'h9ABCDEF0,
            32'h12345678, 32'h9ABCDEF0, 16'h0E00}};
    accumulator_pair_shift_unit uut (.pclk(pclk), .presetn(presetn),
        .clk_en(1'h1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    initial forever #10 pclk = ~pclk;
    task give_verdict;
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n == 20)
            fails++;
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        foreach (regs[k]) begin
            apb(1'h0, regs[k], '0);
            chk(r, '0);
        end
        foreach (rows[i]) begin
            apb(1'h1, `ADDR_STATUS1, 32'(rows[i].st));
            apb(1'h1, `ADDR_ACC, rows[i].a);
            apb(1'h1, `ADDR_BUF, rows[i].b);
            apb(1'h1, `ADDR_OPCODE, 32'(rows[i].op));
            apb(1'h0, `ADDR_ACC, '0);
            chk(r, rows[i].ea);
            apb(1'h0, `ADDR_BUF, '0);
            chk(r, rows[i].eb);
            apb(1'h0, `ADDR_STATUS1, '0);
            chk(r, 32'(rows[i].es));
            apb(1'h0, `ADDR_PC, '0);
            chk(r, 32'(i + 1));
        end
        // Two shifts in a row chain through the updated pair
        apb(1'h1, `ADDR_OPCODE, 32'(`OPC_SFL));
        apb(1'h1, `ADDR_OPCODE, 32'(`OPC_SFL));
        apb(1'h0, `ADDR_ACC, '0);
        chk(r, 32'h48D159E2);
        apb(1'h0, `ADDR_PC, '0);
        chk(r, 32'hA);
        apb(1'h0, 12'h100, '0);
        chk(32'(e), 32'h1);
        give_verdict;
    end
    initial begin
        #100000;
        fails++;
        give_verdict;
    end
endmodule
bind accumulator_pair_shift_unit shift_unit_props u_props (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
`default_nettype wire
